// file: logic/mkci_top.sv
// keypad interpreter with apb register access
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module mkci_top import mkci_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire mkci_apb_req_type apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mute_on,
  input wire logic [7:0] rx_char,
  input wire logic rx_valid,
  input wire logic tx_ready,
  input wire logic baud_tick,
  input wire logic [15:0] option_bits,
  output logic [7:0] tx_char,
  output logic tx_valid,
  output logic remote_cmd_enable,
  output logic keyline,
  output logic tones_enable,
  output logic tx_mark_level,
  output logic [3:0] test_code,
  output logic [2:0] option_page,
  output logic two_tone_lamp,
  output logic mark_only_lamp,
  output logic space_only_lamp,
  output logic entry_lamp,
  output logic entry_flash,
  output logic [1:0] blank_window,
  output logic self_test_start
);
  mkci_state_type state;
  mkci_disc_type disc_live, disc_saved;
  mkci_test_type test_sel;
  mkci_freq_type freq_live [2];
  mkci_freq_type freq_saved [2];
  logic center_mode, chan2, edit_space, alt_phase;
  logic [19:0] entry_val;
  logic [7:0] sent_idx;
  logic [2:0] page;
  logic rd_wait;

  // apb decode
  wire logic acc = apb_req.psel && apb_req.penable;
  wire logic wr = acc && apb_req.pwrite;
  wire logic [7:0] a = apb_req.paddr;
  wire logic hit = a == ADDR_KEY || a == ADDR_STATUS || a == ADDR_MARK0 ||
    a == ADDR_SPACE0 || a == ADDR_MARK1 || a == ADDR_SPACE1 ||
    a == ADDR_ENTRY || a == ADDR_RXCHAR || a == ADDR_OPTIONS;
  // reads take one wait state so registered data stands
  wire logic rd_acc = acc && !apb_req.pwrite;
  assign pready = !rd_acc || rd_wait;
  assign pslverr = acc && !hit;
  wire logic key_wr = wr && a == ADDR_KEY;
  wire logic [4:0] k = apb_req.pwdata[4:0];
  wire logic is_digit = k <= 5'h09;

  // tenths of hertz
  // tenth digit and value math
  wire logic [19:0] ev10 = 20'(entry_val * 20'd10);
  wire logic [3:0] tenth = 4'(entry_val % 20'd10);
  wire logic [19:0] halfv = (tenth == 4'd5) ? entry_val - 20'd5 :
    entry_val - 20'(tenth) + 20'd5;
  wire logic [19:0] new_digit = 20'((ev10 - 20'(tenth) * 20'd10) / 20'd10 *
    20'd10 + 20'(k) * 20'd10);
  wire mkci_freq_type cur = freq_live[chan2];
  wire logic [19:0] shift_v = cur.space - cur.mark;
  wire logic [19:0] cent_v = cur.mark + (shift_v >> 1);
  wire logic [19:0] half_e = entry_val >> 1;
  // status word
  wire logic [31:0] status_w = {10'h000, 1'b0, entry_flash, entry_lamp,
    center_mode, chan2, disc_live, disc_saved, state, test_sel, page,
    remote_cmd_enable, keyline, tones_enable};

  always_ff @(posedge mclk) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      rd_wait <= 1'b0;
    end else begin
      rd_wait <= rd_acc && !rd_wait;
      if (rd_acc) begin
        unique case (a)
          ADDR_STATUS: prdata <= status_w;
          ADDR_MARK0: prdata <= {12'h000, freq_live[0].mark};
          ADDR_SPACE0: prdata <= {12'h000, freq_live[0].space};
          ADDR_MARK1: prdata <= {12'h000, freq_live[1].mark};
          ADDR_SPACE1: prdata <= {12'h000, freq_live[1].space};
          ADDR_ENTRY: prdata <= {12'h000, entry_val};
          ADDR_RXCHAR: prdata <= {24'h000000, rx_char};
          ADDR_OPTIONS: prdata <= {16'h0000, option_bits};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // key interpreter
  always_ff @(posedge mclk) begin
    if (rst) begin
      state <= ST_IDLE;
      disc_live <= DM_TWO;
      disc_saved <= DM_TWO;
      test_sel <= TS_NONE;
      center_mode <= 1'b0;
      chan2 <= 1'b0;
      edit_space <= 1'b0;
      entry_val <= 20'h00000;
      page <= 3'h0;
      entry_lamp <= 1'b0;
      entry_flash <= 1'b0;
      blank_window <= 2'b00;
      self_test_start <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        freq_live[i] <= '{mark: RST_MARK, space: RST_SPACE};
        freq_saved[i] <= '{mark: RST_MARK, space: RST_SPACE};
      end
    end else begin
      self_test_start <= 1'b0;
      entry_flash <= 1'b0;
      if (key_wr) begin
        unique case (state)
          ST_IDLE: begin
            if (k == KEY_PREFIX) begin
              state <= ST_PREFIX;
            end else if (k == KEY_SHIFT) begin
              disc_live <= DM_TWO;
              entry_lamp <= 1'b1;
            end else if (k == KEY_MARK || k == KEY_SPACE) begin
              state <= ST_EDIT;
              edit_space <= k == KEY_SPACE;
              entry_val <= 20'h00000;
              blank_window <= (k == KEY_SPACE) ? 2'b10 : 2'b01;
              entry_lamp <= 1'b1;
            end else if (k == KEY_DMODE) begin
              center_mode <= 1'b0;
            end else if (k == KEY_CHANNEL_SELECT_KEY) begin
              chan2 <= !chan2;
            end else if (k == KEY_ENTER) begin
              disc_saved <= disc_live;
              freq_saved <= freq_live;
              entry_lamp <= 1'b0;
            end else if (k == KEY_CLEAR) begin
              disc_live <= disc_saved;
              freq_live <= freq_saved;
              entry_lamp <= 1'b0;
            end
          end
          ST_PREFIX: begin
            state <= ST_IDLE;
            if (k == KEY_TEST) begin
              state <= ST_TESTSEL;
            end else if (k == KEY_MARK) begin
              disc_live <= DM_MARK;
              entry_lamp <= 1'b1;
            end else if (k == KEY_SPACE) begin
              disc_live <= DM_SPACE;
              entry_lamp <= 1'b1;
            end else if (k == KEY_DMODE) begin
              center_mode <= 1'b1;
            end
          end
          ST_TESTSEL: begin
            state <= ST_IDLE;
            if (test_sel == TS_NONE) begin
              if (k == KEY_ENTER) begin
                self_test_start <= 1'b1;
              end else if (is_digit && k >= 5'h01 && k <= 5'h07) begin
                test_sel <= mkci_test_type'(k[3:0]);
                state <= ST_TESTSEL;
              end else if (k == KEY_HALF) begin
                test_sel <= TS_ECHO;
                state <= ST_TESTSEL;
              end else if (k == KEY_REMOTE) begin
                test_sel <= TS_PORT;
                state <= ST_TESTSEL;
              end else if (k == KEY_CHANNEL_SELECT_KEY) begin
                state <= ST_OPTIONS;
                page <= 3'h0;
              end
            end else if (k == KEY_ENTER) begin
              if (test_sel == TS_AUTO) begin
                self_test_start <= 1'b1;
                test_sel <= TS_NONE;
              end else begin
                state <= ST_TESTRUN;
              end
            end else begin
              test_sel <= TS_NONE;
            end
          end
          ST_TESTRUN: begin
            test_sel <= TS_NONE;
            state <= ST_IDLE;
          end
          ST_OPTIONS: begin
            if (k == KEY_ENTER && page < OPT_PAGES - 3'h1) begin
              page <= page + 3'h1;
            end else begin
              state <= ST_IDLE;
              page <= 3'h0;
            end
          end
          ST_EDIT: begin
            if (is_digit) begin
              entry_val <= new_digit;
            end else if (k == KEY_HALF) begin
              entry_val <= halfv;
            end else if (k == KEY_ENTER) begin
              state <= ST_IDLE;
              blank_window <= 2'b00;
              entry_flash <= 1'b1;
              entry_lamp <= 1'b0;
              if (!center_mode && !edit_space) begin
                freq_live[chan2].mark <= entry_val;
              end else if (!center_mode) begin
                freq_live[chan2].space <= entry_val;
              end else if (!edit_space) begin
                freq_live[chan2].mark <= entry_val - (shift_v >> 1);
                freq_live[chan2].space <= entry_val + (shift_v >> 1);
              end else begin
                freq_live[chan2].mark <= cent_v - half_e;
                freq_live[chan2].space <= cent_v + half_e;
              end
            end else begin
              state <= ST_IDLE;
              blank_window <= 2'b00;
              entry_lamp <= 1'b0;
              freq_live <= freq_saved;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // remote port test traffic
  wire logic port_test = state == ST_TESTRUN &&
    (test_sel == TS_ECHO || test_sel == TS_PORT);
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_char <= 8'h00;
      tx_valid <= 1'b0;
      sent_idx <= 8'h00;
      alt_phase <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) tx_valid <= 1'b0;
      if (baud_tick) alt_phase <= !alt_phase;
      if (state == ST_TESTRUN && test_sel == TS_ECHO && rx_valid) begin
        tx_char <= rx_char;
        tx_valid <= 1'b1;
      end else if (state == ST_TESTRUN && test_sel == TS_PORT &&
          (!tx_valid || tx_ready)) begin
        tx_char <= 8'h41 + sent_idx[7:0] % 8'h1a;
        tx_valid <= 1'b1;
        sent_idx <= (sent_idx == SENT_LEN - 8'h01) ? 8'h00 : sent_idx + 8'h01;
      end
    end
  end

  wire logic tone_test = state == ST_TESTRUN &&
    (test_sel == TS_MARK || test_sel == TS_SPACE || test_sel == TS_ALT);
  assign remote_cmd_enable = !port_test;
  assign keyline = tone_test;
  assign tones_enable = tone_test || !mute_on;
  assign tx_mark_level = test_sel == TS_ALT ? alt_phase : test_sel != TS_SPACE;
  assign test_code = state == ST_TESTRUN ? test_sel : TS_NONE;
  assign option_page = page;
  assign two_tone_lamp = disc_live == DM_TWO;
  assign mark_only_lamp = disc_live == DM_MARK;
  assign space_only_lamp = disc_live == DM_SPACE;
endmodule
`default_nettype wire

// file: pkg/mkci_pkg.sv
// package for the modem keypad command interpreter
// Overview of operation
// - prefix, test key, then entry or digit
// - entry alone or test 1: self-test
// - tests 2,3,4 mark/space/alternate; 8,9,0 none
// - tests 5,6,7 loopback, own display code
// - running tests end on any key
// - port tests suspend remote command handling
// - echo test loops received characters back
// - message test sends sentence continuously
// - tests 2-4 key line, override mute
// - prefix, test, channel: option pages on entry
// - prefix affects listed keys only
// - shift key selects two-tone mode
// - prefix mark selects mark-only mode
// - mode change pending until entry
// - mark key edits mark per channel
// - space key edits space per channel
// - edit blanks, lamp on, entry applies
// - half-unit key toggles tenths digit
// - center edit keeps shift
// - shift edit keeps center
// - clear restores saved settings
// - digits only after opening key
// - prefix space selects space-only mode
package mkci_pkg;
  localparam logic [4:0] KEY_HALF = 5'h0a;
  localparam logic [4:0] KEY_ENTER = 5'h0b;
  localparam logic [4:0] KEY_CLEAR = 5'h0c;
  localparam logic [4:0] KEY_PREFIX = 5'h0d;
  localparam logic [4:0] KEY_TEST = 5'h0e;
  localparam logic [4:0] KEY_MARK = 5'h0f;
  localparam logic [4:0] KEY_SPACE = 5'h10;
  localparam logic [4:0] KEY_SHIFT = 5'h11;
  localparam logic [4:0] KEY_DMODE = 5'h12;
  localparam logic [4:0] KEY_CHANNEL_SELECT_KEY = 5'h13;
  localparam logic [4:0] KEY_HOLD = 5'h14;
  localparam logic [4:0] KEY_POL = 5'h15;
  localparam logic [4:0] KEY_SYNC = 5'h16;
  localparam logic [4:0] KEY_REMOTE = 5'h17;
  localparam logic [4:0] KEY_BAUD = 5'h18;
  localparam logic [4:0] KEY_OTHER = 5'h19;
  // apb map
  localparam logic [7:0] ADDR_KEY = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_MARK0 = 8'h08;
  localparam logic [7:0] ADDR_SPACE0 = 8'h0c;
  localparam logic [7:0] ADDR_MARK1 = 8'h10;
  localparam logic [7:0] ADDR_SPACE1 = 8'h14;
  localparam logic [7:0] ADDR_ENTRY = 8'h18;
  localparam logic [7:0] ADDR_RXCHAR = 8'h1c;
  localparam logic [7:0] ADDR_OPTIONS = 8'h20;
  // reset values in tenths of hertz
  localparam logic [19:0] RST_MARK = 20'h03d86;
  localparam logic [19:0] RST_SPACE = 20'h05f0a;
  localparam logic [2:0] OPT_PAGES = 3'h6;
  localparam logic [7:0] SENT_LEN = 8'h2c;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_PREFIX = 3'b001, ST_TESTSEL = 3'b010,
    ST_TESTRUN = 3'b011, ST_OPTIONS = 3'b100, ST_EDIT = 3'b101
  } mkci_state_type;
  typedef enum logic [1:0] {
    DM_TWO = 2'b00, DM_MARK = 2'b01, DM_SPACE = 2'b10
  } mkci_disc_type;
  typedef enum logic [3:0] {
    TS_NONE = 4'h0, TS_AUTO = 4'h1, TS_MARK = 4'h2, TS_SPACE = 4'h3,
    TS_ALT = 4'h4, TS_LP1 = 4'h5, TS_LP2 = 4'h6, TS_LP3 = 4'h7,
    TS_ECHO = 4'h8, TS_PORT = 4'h9
  } mkci_test_type;
  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } mkci_apb_req_type;
  typedef struct packed {
    logic [19:0] mark;
    logic [19:0] space;
  } mkci_freq_type;
endpackage

// file: dv/mkci_chk.sv
// concurrent checks on the keypad interpreter ports
`timescale 1ns/100ps
`default_nettype none
module mkci_chk import mkci_pkg::*; (
  input wire logic mclk,
  input wire logic rst,
  input wire mkci_apb_req_type apb_req,
  input wire logic pready,
  input wire logic [3:0] test_code,
  input wire logic keyline,
  input wire logic tones_enable,
  input wire logic remote_cmd_enable,
  input wire logic rx_valid,
  input wire logic tx_valid,
  input wire logic entry_flash,
  input wire logic entry_lamp,
  input wire logic [1:0] blank_window,
  input wire logic two_tone_lamp,
  input wire logic mark_only_lamp,
  input wire logic space_only_lamp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire key_wr = apb_req.psel && apb_req.penable && apb_req.pwrite
    && apb_req.paddr == ADDR_KEY;
  wire tone_test = test_code inside {4'h2, 4'h3, 4'h4};
  property p_lamp;
    $onehot({two_tone_lamp, mark_only_lamp, space_only_lamp});
  endproperty
  a_lamp: assert property (p_lamp) else $error("mode lamps not one-hot");
  property p_tone;
    tone_test |-> keyline && tones_enable;
  endproperty
  a_tone: assert property (p_tone) else $error("tone test without key");
  property p_remote;
    test_code inside {4'h8, 4'h9} |-> !remote_cmd_enable;
  endproperty
  a_remote: assert property (p_remote) else $error("remote not held");
  property p_echo;
    test_code == 4'h8 && rx_valid |-> ##[1:6] tx_valid;
  endproperty
  a_echo: assert property (p_echo) else $error("no echo");
  property p_msg;
    test_code == 4'h9 |-> ##[0:60] tx_valid;
  endproperty
  a_msg: assert property (p_msg) else $error("message paused");
  property p_end;
    key_wr && test_code inside {[4'h2:4'h7]} |-> ##[1:2] test_code == 4'h0;
  endproperty
  a_end: assert property (p_end) else $error("test kept running");
  property p_flash;
    entry_flash |-> ##[0:1] !entry_lamp;
  endproperty
  a_flash: assert property (p_flash) else $error("lamp on at entry");
  property p_blank;
    $rose(|blank_window) |-> entry_lamp;
  endproperty
  a_blank: assert property (p_blank) else $error("blank without lamp");
  property p_ready;
    apb_req.psel && apb_req.penable |-> ##[0:1] pready;
  endproperty
  a_ready: assert property (p_ready) else $error("apb not answered");
  cover property (test_code == 4'h8 && rx_valid);
  cover property ($rose(entry_flash));
  cover property (mark_only_lamp);
endmodule
bind mkci_top mkci_chk chk_u (.mclk(mclk), .rst(rst), .apb_req(apb_req),
  .pready(pready), .test_code(test_code), .keyline(keyline),
  .tones_enable(tones_enable), .remote_cmd_enable(remote_cmd_enable),
  .rx_valid(rx_valid), .tx_valid(tx_valid), .entry_flash(entry_flash),
  .entry_lamp(entry_lamp), .blank_window(blank_window),
  .two_tone_lamp(two_tone_lamp), .mark_only_lamp(mark_only_lamp),
  .space_only_lamp(space_only_lamp));
`default_nettype wire

// file: dv/mkci_remote_term.sv
// remote terminal model on the remote port
`timescale 1ns/100ps
`default_nettype none
module mkci_remote_term (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [7:0] tx_char,
  input wire logic tx_valid,
  input wire logic slow,
  output logic tx_ready,
  output logic [7:0] rx_char,
  output logic rx_valid,
  output logic [7:0] last_char,
  output logic [15:0] got_count
);
  initial begin
    rx_char = 8'hff;
    rx_valid = 1'b0;
  end
  // one character pulse, then the line scrambles
  task automatic send(input logic [7:0] c);
    @(posedge mclk);
    rx_char <= c;
    rx_valid <= 1'b1;
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_char <= ~c;
  endtask
  always_ff @(posedge mclk) begin
    if (rst) begin
      tx_ready <= 1'b0;
      got_count <= 16'h0;
      last_char <= 8'h0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
      if (tx_valid && tx_ready) begin
        got_count <= got_count + 16'h1;
        last_char <= tx_char;
      end
    end
  end
endmodule
`default_nettype wire

// file: dv/mkci_top_bench.sv
// self-checking bench for the keypad interpreter
`timescale 1ns/100ps
`default_nettype none
module mkci_top_bench import mkci_pkg::*;;
  logic mclk, rst, mute_on, slow, err, st_seen;
  mkci_apb_req_type req;
  logic [31:0] prdata;
  logic pready, pslverr, tx_valid, tx_ready, rx_valid, self_test_start;
  logic [7:0] tx_char, rx_char, last_char;
  logic [15:0] got_count;
  logic [3:0] test_code;
  logic [1:0] blank_window;
  logic keyline, tones_enable, remote_cmd_enable, two_tone_lamp;
  logic mark_only_lamp, space_only_lamp, entry_lamp, tx_mark_level;
  logic [2:0] option_page;
  int fail_count = 0;
  int total_checks = 0;
  mkci_top dut_u (.mclk(mclk), .rst(rst), .apb_req(req), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mute_on(mute_on),
    .rx_char(rx_char), .rx_valid(rx_valid), .tx_ready(tx_ready),
    .baud_tick(1'b0), .option_bits(16'h0), .tx_char(tx_char),
    .tx_valid(tx_valid), .remote_cmd_enable(remote_cmd_enable),
    .keyline(keyline), .tones_enable(tones_enable),
    .tx_mark_level(tx_mark_level), .test_code(test_code),
    .option_page(option_page), .two_tone_lamp(two_tone_lamp),
    .mark_only_lamp(mark_only_lamp), .space_only_lamp(space_only_lamp),
    .entry_lamp(entry_lamp), .entry_flash(), .blank_window(blank_window),
    .self_test_start(self_test_start));
  mkci_remote_term partner_u (.mclk(mclk), .rst(rst), .tx_char(tx_char),
    .tx_valid(tx_valid), .slow(slow), .tx_ready(tx_ready),
    .rx_char(rx_char), .rx_valid(rx_valid), .last_char(last_char),
    .got_count(got_count));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) if (self_test_start === 1'b1) st_seen <= 1'b1;
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q);
    int n;
    n = 0;
    req.paddr <= a;
    req.pwrite <= w;
    req.pwdata <= d;
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    @(posedge mclk);
    req.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      fail_count++;
      test_done();
    end
    err = pslverr;
    q = prdata;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic key(input logic [4:0] k);
    logic [31:0] q;
    apb(ADDR_KEY, 1'b1, {27'h0, k}, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    apb(a, 1'b0, 32'h0, q);
    chk(q, e);
  endtask
  task automatic bit_test(input logic [4:0] k);
    key(KEY_PREFIX);
    key(KEY_TEST);
    key(k);
    key(KEY_ENTER);
  endtask
  task automatic wait_cnt(input logic [15:0] n);
    int i;
    for (i = 0; i < 2000 && got_count < n; i++) @(posedge mclk);
    if (got_count < n) begin
      fail_count++;
      test_done();
    end
  endtask
  task automatic edit4(input logic [4:0] f, input logic [15:0] v);
    key(f);
    for (int i = 3; i >= 0; i--) key({1'b0, v[4*i+:4]});
    key(KEY_ENTER);
  endtask
  initial begin
    req = '0;
    mute_on = 1'b1;
    slow = 1'b0;
    st_seen = 1'b0;
    rst = 1'b1;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chk({remote_cmd_enable, two_tone_lamp}, 2'b11);
    rd(ADDR_MARK0, 32'h3d86);
    rd(8'hfc, 32'h0);
    chk(err, 1'b1);
    $display("test reset done");
    for (int k = 2; k <= 8; k++) begin
      bit_test(k[4:0]);
      chk(test_code, (k == 8) ? 4'h0 : k[3:0]);
      if (k < 5) chk({keyline, tones_enable}, 2'b11);
      if (k == 2) chk(tx_mark_level, 1'b1);
      if (k == 3) chk(tx_mark_level, 1'b0);
      key(KEY_OTHER);
      chk(test_code, 4'h0);
    end
    bit_test(4'h1);
    key(KEY_PREFIX);
    key(KEY_TEST);
    key(KEY_CHANNEL_SELECT_KEY);
    key(KEY_ENTER);
    chk(option_page, 3'h1);
    key(KEY_OTHER);
    chk(st_seen, 1'b1);
    $display("test bit done");
    bit_test(KEY_HALF);
    chk(remote_cmd_enable, 1'b0);
    partner_u.send(8'h5a);
    wait_cnt(16'h1);
    chk(last_char, 8'h5a);
    key(KEY_OTHER);
    slow = 1'b1;
    bit_test(KEY_REMOTE);
    wait_cnt(16'h4);
    key(KEY_OTHER);
    chk(remote_cmd_enable, 1'b1);
    $display("test port done");
    key(KEY_PREFIX);
    key(KEY_MARK);
    chk(mark_only_lamp, 1'b1);
    key(KEY_ENTER);
    key(KEY_PREFIX);
    key(KEY_SPACE);
    chk(space_only_lamp, 1'b1);
    key(KEY_SHIFT);
    chk(two_tone_lamp, 1'b1);
    key(KEY_CLEAR);
    chk(mark_only_lamp, 1'b1);
    $display("test mode done");
    key(KEY_DMODE);
    key(KEY_MARK);
    chk({blank_window, entry_lamp}, 3'b011);
    key(4'h2);
    key(4'h1);
    key(4'h2);
    key(4'h5);
    key(KEY_HALF);
    key(KEY_HALF);
    key(KEY_ENTER);
    rd(ADDR_MARK0, 32'h5302);
    edit4(KEY_SPACE, 16'h2295);
    rd(ADDR_SPACE0, 32'h59a6);
    key(KEY_CHANNEL_SELECT_KEY);
    edit4(KEY_MARK, 16'h1000);
    rd(ADDR_MARK1, 32'h2710);
    key(KEY_CHANNEL_SELECT_KEY);
    key(KEY_PREFIX);
    key(KEY_DMODE);
    edit4(KEY_MARK, 16'h2000);
    rd(ADDR_MARK0, 32'h4ace);
    rd(ADDR_SPACE0, 32'h5172);
    edit4(KEY_SPACE, 16'h0200);
    rd(ADDR_MARK0, 32'h4a38);
    rd(ADDR_SPACE0, 32'h5208);
    $display("test freq done");
    test_done();
  end
endmodule
`default_nettype wire
